// >>> core/csf_regs.sv
`timescale 1ns/1ps

// Overview of operation
// - word A bits 7 and 6 show second and first input blocking pair fitted.
// - word A bit 5 is one when the one-shot conversion has finished.
// - word A bit 4 is one while minimum system voltage regulation holds.
// - word A bits 3,2,1 show fast, trickle, precharge safety timer expired.
// - word A at 1Eh, read-only, zero at reset, bit 0 reads zero.
// - word B at 1Fh, read-only, zero at reset, bits 7 to 5 zero.
// - word B bit 4 is one when battery too low for boost.
// - word B bit 3 is one in the cold thermistor zone.
// - word B bit 2 is one in the cool thermistor zone.
// - word B bit 1 is one in the warm thermistor zone.
// - word B bit 0 is one in the hot thermistor zone.
// - protection word at 20h, eight read-only fields, zero at reset.
// - protection bit 7 is one while discharge current is being limited.
// - protection bits 6,5,1,0 show bus, battery, second, first input overvoltage.
// - protection bits 4 and 3 show input and battery overcurrent.
// - protection bit 2 is one while converter overcurrent protection is active.
module csf_regs
	import csf_pkg::*;
#(
	parameter logic [6:0] DEV_ADDR = CSF_DEF_DEV_ADDR
) (
	input  wire logic clk,
	input  wire logic nrst,
	// serial port, open drain data line
	input  wire logic scl_i,
	input  wire logic sda_i,
	output logic      sda_o,
	output logic      sda_oe,
	// live conditions from the analog detectors
	input  wire logic input_pair_two_fitted,
	input  wire logic input_pair_one_fitted,
	input  wire logic adc_one_shot_done,
	input  wire logic min_system_regulating,
	input  wire logic fast_charge_timer_expired,
	input  wire logic trickle_timer_expired,
	input  wire logic precharge_timer_expired,
	input  wire logic battery_too_low_for_boost,
	input  wire logic thermistor_cold_zone,
	input  wire logic thermistor_cool_zone,
	input  wire logic thermistor_warm_zone,
	input  wire logic thermistor_hot_zone,
	input  wire logic discharge_current_limiting,
	input  wire logic bus_input_overvoltage,
	input  wire logic battery_overvoltage,
	input  wire logic input_overcurrent,
	input  wire logic battery_overcurrent,
	input  wire logic converter_overcurrent,
	input  wire logic second_input_overvoltage,
	input  wire logic first_input_overvoltage
);

	logic [7:0] raw_a;
	logic [7:0] raw_b;
	logic [7:0] raw_p;
	logic [7:0] charger_condition_word_a;
	logic [7:0] charger_condition_word_b;
	logic [7:0] protection_condition_word;
	logic [1:0] pins;

	// place each detector on its field; reserved bits stay tied low
	always_comb begin
		raw_a = CSF_RST_WORD_A;
		raw_a[CSF_A_PAIR_TWO_BIT]    = input_pair_two_fitted;
		raw_a[CSF_A_PAIR_ONE_BIT]    = input_pair_one_fitted;
		raw_a[CSF_A_ADC_DONE_BIT]    = adc_one_shot_done;
		raw_a[CSF_A_MIN_SYS_BIT]     = min_system_regulating;
		raw_a[CSF_A_FAST_TMR_BIT]    = fast_charge_timer_expired;
		raw_a[CSF_A_TRICKLE_TMR_BIT] = trickle_timer_expired;
		raw_a[CSF_A_PRE_TMR_BIT]     = precharge_timer_expired;
		raw_b = CSF_RST_WORD_B;
		raw_b[CSF_B_BOOST_LOW_BIT]   = battery_too_low_for_boost;
		raw_b[CSF_B_COLD_BIT]        = thermistor_cold_zone;
		raw_b[CSF_B_COOL_BIT]        = thermistor_cool_zone;
		raw_b[CSF_B_WARM_BIT]        = thermistor_warm_zone;
		raw_b[CSF_B_HOT_BIT]         = thermistor_hot_zone;
		raw_p = CSF_RST_PROT;
		raw_p[CSF_P_DISCH_LIMIT_BIT] = discharge_current_limiting;
		raw_p[CSF_P_BUS_OV_BIT]      = bus_input_overvoltage;
		raw_p[CSF_P_BAT_OV_BIT]      = battery_overvoltage;
		raw_p[CSF_P_IN2_OV_BIT]      = second_input_overvoltage;
		raw_p[CSF_P_IN1_OV_BIT]      = first_input_overvoltage;
		raw_p[CSF_P_IN_OC_BIT]       = input_overcurrent;
		raw_p[CSF_P_BAT_OC_BIT]      = battery_overcurrent;
		raw_p[CSF_P_CONV_OC_BIT]     = converter_overcurrent;
	end

	// status words are the synchronised live levels, no latching
	csf_sync #(.W(8)) u_sync_a (
		.clk  (clk),
		.nrst (nrst),
		.din  (raw_a),
		.dout (charger_condition_word_a)
	);

	csf_sync #(.W(8)) u_sync_b (
		.clk  (clk),
		.nrst (nrst),
		.din  (raw_b),
		.dout (charger_condition_word_b)
	);

	csf_sync #(.W(8)) u_sync_p (
		.clk  (clk),
		.nrst (nrst),
		.din  (raw_p),
		.dout (protection_condition_word)
	);

	// pins pass inverted, so the filter's zero reset reads as an idle high bus (no false edge)
	csf_sync #(.W(2)) u_sync_pins (
		.clk  (clk),
		.nrst (nrst),
		.din  (~{scl_i, sda_i}),
		.dout (pins)
	);

	logic scl;
	logic sda;
	assign scl = ~pins[1];
	assign sda = ~pins[0];

	// ------------------------------------------------------------------
	// bus event detection
	// ------------------------------------------------------------------
	logic scl_q;
	logic sda_q;
	logic next_scl_q;
	logic next_sda_q;
	logic scl_rise;
	logic scl_fall;
	logic start_seen;
	logic stop_seen;

	// edges are judged on the filtered levels, so a bounce cannot fake one
	always_comb begin
		next_scl_q = scl;
		next_sda_q = sda;
		scl_rise   = scl & ~scl_q;
		scl_fall   = ~scl & scl_q;
		start_seen = scl & scl_q & sda_q & ~sda;
		stop_seen  = scl & scl_q & ~sda_q & sda;
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else begin
			scl_q <= next_scl_q;
			sda_q <= next_sda_q;
		end
	end

	// ------------------------------------------------------------------
	// read mux: pure selection, a read never changes a status bit
	// ------------------------------------------------------------------
	function automatic logic [7:0] read_word(input logic [7:0] ofs,
	                                         input logic [7:0] wa,
	                                         input logic [7:0] wb,
	                                         input logic [7:0] wp);
		logic [7:0] val;
		case (ofs)
			CSF_OFS_WORD_A: val = wa;
			CSF_OFS_WORD_B: val = wb;
			CSF_OFS_PROT:   val = wp;
			default:        val = CSF_RST_UNMAPPED;
		endcase
		return val;
	endfunction

	// ------------------------------------------------------------------
	// serial slave state machine
	// ------------------------------------------------------------------
	csf_state_t state;
	csf_state_t next_state;
	logic [7:0] shreg;
	logic [7:0] next_shreg;
	logic [7:0] txreg;
	logic [7:0] next_txreg;
	logic [7:0] ptr;
	logic [7:0] next_ptr;
	logic [3:0] bitcnt;
	logic [3:0] next_bitcnt;
	logic       rw;
	logic       next_rw;
	logic       nack;
	logic       next_nack;
	logic       next_sda_oe;
	logic [7:0] rd_val;

	assign rd_val = read_word(ptr, charger_condition_word_a,
	                          charger_condition_word_b, protection_condition_word);

	// bits are taken on scl rise; the line is only changed after scl fall
	always_comb begin
		next_state  = state;
		next_shreg  = shreg;
		next_txreg  = txreg;
		next_ptr    = ptr;
		next_bitcnt = bitcnt;
		next_rw     = rw;
		next_nack   = nack;
		next_sda_oe = sda_oe;
		if (start_seen) begin
			// repeated start keeps the pointer for a combined write-read
			next_state  = CSF_ST_ADDR;
			next_bitcnt = 4'h0;
			next_sda_oe = 1'b0;
		end else if (stop_seen) begin
			next_state  = CSF_ST_IDLE;
			next_sda_oe = 1'b0;
		end else if (scl_rise) begin
			case (state)
				CSF_ST_ADDR, CSF_ST_PTR, CSF_ST_WDATA: begin
					next_shreg  = {shreg[6:0], sda};
					next_bitcnt = bitcnt + 4'h1;
				end
				CSF_ST_RDATA: begin
					next_bitcnt = bitcnt + 4'h1;
				end
				CSF_ST_RDATA_ACK: begin
					next_nack = sda;
				end
				default: begin
				end
			endcase
		end else if (scl_fall) begin
			case (state)
				CSF_ST_ADDR: begin
					if (bitcnt == CSF_BITS_PER_BYTE) begin
						if (shreg[7:1] == DEV_ADDR) begin
							next_rw     = shreg[0];
							next_sda_oe = 1'b1;
							next_state  = CSF_ST_ADDR_ACK;
						end else begin
							// other device addressed; stay off the line until the next start
							next_state = CSF_ST_IDLE;
						end
					end
				end
				CSF_ST_ADDR_ACK: begin
					next_bitcnt = 4'h0;
					if (rw) begin
						next_txreg  = rd_val;
						next_sda_oe = ~rd_val[7];
						next_state  = CSF_ST_RDATA;
					end else begin
						next_sda_oe = 1'b0;
						next_state  = CSF_ST_PTR;
					end
				end
				CSF_ST_PTR: begin
					if (bitcnt == CSF_BITS_PER_BYTE) begin
						next_ptr    = shreg;
						next_sda_oe = 1'b1;
						next_state  = CSF_ST_PTR_ACK;
					end
				end
				CSF_ST_PTR_ACK, CSF_ST_WDATA_ACK: begin
					next_sda_oe = 1'b0;
					next_bitcnt = 4'h0;
					next_state  = CSF_ST_WDATA;
				end
				CSF_ST_WDATA: begin
					// all words here are read-only: data is acknowledged and dropped
					if (bitcnt == CSF_BITS_PER_BYTE) begin
						next_ptr    = ptr + 8'h01;
						next_sda_oe = 1'b1;
						next_state  = CSF_ST_WDATA_ACK;
					end
				end
				CSF_ST_RDATA: begin
					if (bitcnt == CSF_BITS_PER_BYTE) begin
						next_sda_oe = 1'b0;
						next_ptr    = ptr + 8'h01;
						next_state  = CSF_ST_RDATA_ACK;
					end else begin
						next_txreg  = {txreg[6:0], 1'b0};
						next_sda_oe = ~txreg[6];
					end
				end
				CSF_ST_RDATA_ACK: begin
					next_bitcnt = 4'h0;
					if (nack) begin
						next_sda_oe = 1'b0;
						next_state  = CSF_ST_IDLE;
					end else begin
						// byte is sampled at its first bit, so it is coherent per word
						next_txreg  = rd_val;
						next_sda_oe = ~rd_val[7];
						next_state  = CSF_ST_RDATA;
					end
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state  <= CSF_ST_IDLE;
			shreg  <= 8'h00;
			txreg  <= 8'h00;
			ptr    <= CSF_RST_PTR;
			bitcnt <= 4'h0;
			rw     <= 1'b0;
			nack   <= 1'b0;
			sda_oe <= 1'b0;
			sda_o  <= 1'b0;
		end else begin
			state  <= next_state;
			shreg  <= next_shreg;
			txreg  <= next_txreg;
			ptr    <= next_ptr;
			bitcnt <= next_bitcnt;
			rw     <= next_rw;
			nack   <= next_nack;
			sda_oe <= next_sda_oe;
			sda_o  <= 1'b0; // open drain: only ever pulls low
		end
	end

endmodule

// >>> pkg/csf_pkg.sv
package csf_pkg;

	// register offsets inside the serial register map
	localparam logic [7:0] CSF_OFS_WORD_A     = 8'h1E;
	localparam logic [7:0] CSF_OFS_WORD_B     = 8'h1F;
	localparam logic [7:0] CSF_OFS_PROT       = 8'h20;

	// reset values
	localparam logic [7:0] CSF_RST_WORD_A     = 8'h00;
	localparam logic [7:0] CSF_RST_WORD_B     = 8'h00;
	localparam logic [7:0] CSF_RST_PROT       = 8'h00;
	localparam logic [7:0] CSF_RST_UNMAPPED   = 8'h00;
	localparam logic [7:0] CSF_RST_PTR        = 8'h00;

	// charger_condition_word_a fields
	localparam int CSF_A_PAIR_TWO_BIT         = 7;
	localparam int CSF_A_PAIR_ONE_BIT         = 6;
	localparam int CSF_A_ADC_DONE_BIT         = 5;
	localparam int CSF_A_MIN_SYS_BIT          = 4;
	localparam int CSF_A_FAST_TMR_BIT         = 3;
	localparam int CSF_A_TRICKLE_TMR_BIT      = 2;
	localparam int CSF_A_PRE_TMR_BIT          = 1;

	// charger_condition_word_b fields
	localparam int CSF_B_BOOST_LOW_BIT        = 4;
	localparam int CSF_B_COLD_BIT             = 3;
	localparam int CSF_B_COOL_BIT             = 2;
	localparam int CSF_B_WARM_BIT             = 1;
	localparam int CSF_B_HOT_BIT              = 0;

	// protection_condition_word fields
	localparam int CSF_P_DISCH_LIMIT_BIT      = 7;
	localparam int CSF_P_BUS_OV_BIT           = 6;
	localparam int CSF_P_BAT_OV_BIT           = 5;
	localparam int CSF_P_IN_OC_BIT            = 4;
	localparam int CSF_P_BAT_OC_BIT           = 3;
	localparam int CSF_P_CONV_OC_BIT          = 2;
	localparam int CSF_P_IN2_OV_BIT           = 1;
	localparam int CSF_P_IN1_OV_BIT           = 0;

	// serial port framing
	localparam logic [3:0] CSF_BITS_PER_BYTE  = 4'h8;
	localparam logic [6:0] CSF_DEF_DEV_ADDR   = 7'h2A; // arbitrary value

	typedef enum {
		CSF_ST_IDLE,
		CSF_ST_ADDR,
		CSF_ST_ADDR_ACK,
		CSF_ST_PTR,
		CSF_ST_PTR_ACK,
		CSF_ST_WDATA,
		CSF_ST_WDATA_ACK,
		CSF_ST_RDATA,
		CSF_ST_RDATA_ACK
	} csf_state_t;

endpackage

// >>> core/csf_sync.sv
`timescale 1ns/1ps

// three-stage synchroniser; the output moves only when stages two and three agree
module csf_sync #(
	parameter int W = 8
) (
	input  wire logic         clk,
	input  wire logic         nrst,
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);

	logic [W-1:0] s1;
	logic [W-1:0] s2;
	logic [W-1:0] s3;
	logic [W-1:0] next_dout;

	// per bit, accept the value only after it has held for two samples
	always_comb begin
		for (int i = 0; i < W; i++) begin
			next_dout[i] = (s2[i] == s3[i]) ? s3[i] : dout[i];
		end
	end

	// first stage feeds the second stage only, to keep metastability contained
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			s1   <= '0;
			s2   <= '0;
			s3   <= '0;
			dout <= '0;
		end else begin
			s1   <= din;
			s2   <= s1;
			s3   <= s2;
			dout <= next_dout;
		end
	end

endmodule

// >>> verification/csf_regs_assertions.sv
`timescale 1ns/1ps

// pin-level checks of the serial port; the status words show only through reads
module csf_regs_checker (
	input wire logic clk,
	input wire logic nrst,
	input wire logic scl_i,
	input wire logic sda_i,
	input wire logic sda_o,
	input wire logic sda_oe
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	// open drain: the data pin may only ever be pulled low
	low_drive_only_a: assert property (sda_o == 1'b0) else $error("data pin driven high");
	reset_quiet_a: assert property ($rose(nrst) |-> (!sda_oe) [*8]) else $error("drive after reset");
	// drive changes only in the clock low phase, behind the pin filter
	change_on_low_a: assert property ($changed(sda_oe) |-> !scl_i) else $error("drive moved, clock high");
	change_lag_a: assert property ($changed(sda_oe) |-> !$past(scl_i, 3)) else $error("drive ahead of filter");
	high_phase_hold_a: assert property ($rose(scl_i) |-> ##4 $stable(sda_oe) [*4])
		else $error("drive moved in high phase");
	ack_span_a: assert property ($rose(sda_oe) |=> sda_oe [*8]) else $error("drive too short");
	start_free_a: assert property ((scl_i && $fell(sda_i)) |-> ##[0:6] !sda_oe) else $error("held at start");
	stop_free_a: assert property ((scl_i && $rose(sda_i)) |-> ##[0:6] !sda_oe) else $error("held at stop");

	// main scenarios reached
	cov_start: cover property (scl_i && $fell(sda_i));
	cov_drive: cover property ($rose(sda_oe));
	cov_stop: cover property (scl_i && $rose(sda_i));
endmodule

bind csf_regs csf_regs_checker u_csf_chk (
	.clk   (clk),
	.nrst  (nrst),
	.scl_i (scl_i),
	.sda_i (sda_i),
	.sda_o (sda_o),
	.sda_oe(sda_oe)
);

// >>> verification/csf_host_model.sv
`timescale 1ns/1ps

// bus master: data line released for ones, clock stands high between frames
module csf_host_model (
	input  wire logic clk,
	input  wire logic line,
	output logic      scl,
	output logic      sda
);
	int         h = 10;
	logic       acked;
	logic [7:0] got [4];
	logic [7:0] q_s;
	logic       a_s;

	// idle bus at time zero
	initial begin
		scl = 1'b1;
		sda = 1'b1;
	end

	task automatic wt(input int n);
		repeat (n) @(posedge clk);
	endtask

	// data moves two clocks after the fall, so hold is never broken
	task automatic bit_io(input logic b, output logic r);
		wt(2);
		sda <= b;
		wt(h);
		scl <= 1'b1;
		wt(h);
		r = line;
		scl <= 1'b0;
	endtask

	task automatic byte_io(input logic [7:0] d, input logic ak, output logic [7:0] q, output logic a);
		for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
		bit_io(ak, a);
	endtask

	task automatic start();
		sda <= 1'b1;
		wt(h);
		scl <= 1'b1;
		wt(h);
		sda <= 1'b0;
		wt(h);
		scl <= 1'b0;
	endtask

	task automatic stop();
		wt(2);
		sda <= 1'b0;
		wt(h);
		scl <= 1'b1;
		wt(h);
		sda <= 1'b1;
		wt(h);
	endtask

	task automatic send(input logic [7:0] d);
		byte_io(d, 1'b1, q_s, a_s);
		acked = acked & !a_s;
	endtask

	// pointer write, repeated start, n bytes read, last one refused
	task automatic rd(input logic [6:0] dev, input logic [7:0] ptr, input int n);
		acked = 1'b1;
		start();
		send({dev, 1'b0});
		send(ptr);
		start();
		send({dev, 1'b1});
		for (int i = 0; i < n; i++) byte_io(8'hFF, i == n - 1, got[i], a_s);
		stop();
	endtask

	// plain read from the current pointer, last byte refused
	task automatic rd_cur(input logic [6:0] dev, input int n);
		acked = 1'b1;
		start();
		send({dev, 1'b1});
		for (int i = 0; i < n; i++) byte_io(8'hFF, i == n - 1, got[i], a_s);
		stop();
	endtask

	task automatic wr(input logic [6:0] dev, input logic [7:0] ptr, input logic [7:0] d);
		acked = 1'b1;
		start();
		send({dev, 1'b0});
		send(ptr);
		send(d);
		stop();
	endtask
endmodule

// >>> verification/tb.sv
`timescale 1ns/1ps

module tb
	import csf_pkg::*;
;
	logic        clk = 1'b0;
	logic        nrst = 1'b0;
	logic [7:0]  ca = 8'h00;
	logic [7:0]  cb = 8'h00;
	logic [7:0]  cp = 8'h00;
	logic        scl;
	logic        hsda;
	logic        sda_o;
	logic        sda_oe;
	wire         line;
	logic [31:0] seed = 32'h3A;
	int          num_errors = 0;
	int          num_checks = 0;
	logic [7:0]  expq [$];

	always #2.5 clk = ~clk;

	// open drain wire with pull-up
	assign line = hsda & (sda_oe ? sda_o : 1'b1);

	csf_regs dut (
		.clk(clk), .nrst(nrst), .scl_i(scl), .sda_i(line), .sda_o(sda_o), .sda_oe(sda_oe),
		.input_pair_two_fitted(ca[7]), .input_pair_one_fitted(ca[6]), .adc_one_shot_done(ca[5]),
		.min_system_regulating(ca[4]), .fast_charge_timer_expired(ca[3]), .trickle_timer_expired(ca[2]),
		.precharge_timer_expired(ca[1]), .battery_too_low_for_boost(cb[4]), .thermistor_cold_zone(cb[3]),
		.thermistor_cool_zone(cb[2]), .thermistor_warm_zone(cb[1]), .thermistor_hot_zone(cb[0]),
		.discharge_current_limiting(cp[7]), .bus_input_overvoltage(cp[6]), .battery_overvoltage(cp[5]),
		.input_overcurrent(cp[4]), .battery_overcurrent(cp[3]), .converter_overcurrent(cp[2]),
		.second_input_overvoltage(cp[1]), .first_input_overvoltage(cp[0])
	);

	csf_host_model u_host (.clk(clk), .line(line), .scl(scl), .sda(hsda));

	function logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	// expected word; reserved bits and unmapped offsets read zero
	function automatic logic [7:0] model(input logic [7:0] ofs);
		case (ofs)
			8'h1E: return ca & 8'hFE;
			8'h1F: return cb & 8'h1F;
			8'h20: return cp;
			default: return 8'h00;
		endcase
	endfunction

	task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
		num_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic chk1(input string what, input logic exp, input logic got);
		num_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH %s expected %b seen %b", what, exp, got);
		end
	endtask

	// expectations fixed before the read; conditions hold still meanwhile
	task automatic read_cmp(input logic [7:0] ptr, input int n);
		for (int i = 0; i < n; i++) expq.push_back(model(8'(ptr + i)));
		u_host.rd(CSF_DEF_DEV_ADDR, ptr, n);
		chk1("address ack", 1'b1, u_host.acked);
		for (int i = 0; i < n; i++) chk8("read byte", expq.pop_front(), u_host.got[i]);
	endtask

	task automatic report_and_stop();
		if (num_errors == 0 && num_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// hang guard
	initial begin
		repeat (90000) @(posedge clk);
		num_errors++;
		report_and_stop();
	end

	// main sequence
	initial begin
		logic [31:0] r;
		repeat (5) @(posedge clk);
		nrst <= 1'b1;
		repeat (10) @(posedge clk);
		read_cmp(8'h1E, 4);
		// one condition at a time, reserved positions too
		for (int i = 0; i < 24; i++) begin
			{cp, cb, ca} <= 24'h000001 << i;
			repeat (10) @(posedge clk);
			read_cmp(8'h1E, 3);
		end
		// random mixes, fast and slow master, reread shows no side effect
		for (int i = 0; i < 6; i++) begin
			r = xs();
			{cp, cb, ca} <= r[23:0];
			u_host.h = (i % 2) ? 25 : 10;
			repeat (10) @(posedge clk);
			read_cmp(8'h1E, 3);
			read_cmp(8'h1F, 2);
		end
		u_host.h = 10;
		u_host.wr(CSF_DEF_DEV_ADDR, 8'h1E, 8'hFF);
		chk1("write ack", 1'b1, u_host.acked);
		read_cmp(8'h1E, 3);
		u_host.rd(CSF_DEF_DEV_ADDR ^ 7'h01, 8'h1E, 1);
		chk1("foreign address ack", 1'b0, u_host.acked);
		chk8("foreign read", 8'hFF, u_host.got[0]);
		// a written byte advances the pointer; a plain read goes on from there
		{cp, cb, ca} <= 24'hFFFFFF;
		u_host.wr(CSF_DEF_DEV_ADDR, 8'h1D, 8'h5A);
		chk1("write ack", 1'b1, u_host.acked);
		u_host.rd_cur(CSF_DEF_DEV_ADDR, 1);
		chk8("plain read", model(8'h1E), u_host.got[0]);
		// second reset in mid-run, then live levels again
		nrst <= 1'b0;
		repeat (3) @(posedge clk);
		nrst <= 1'b1;
		repeat (10) @(posedge clk);
		// the pointer left at a mapped word must be back at its reset value
		u_host.rd_cur(CSF_DEF_DEV_ADDR, 1);
		chk8("pointer after reset", model(CSF_RST_PTR), u_host.got[0]);
		read_cmp(8'h1F, 3);
		report_and_stop();
	end
endmodule
